/* hw/sbk_pkg.sv */
package sbk_pkg;

    localparam int unsigned NUM_BANKS = 8;
    localparam int unsigned BANK_W = 3;
    localparam int unsigned ROW_W = 14;
    localparam int unsigned COL_W = 10;
    localparam int unsigned CA_W = 10;
    localparam int unsigned DQ_W = 16;
    localparam int unsigned PIPE_DEPTH = 16;

    // Mode register addresses
    localparam logic [7:0] MA_BURST_CFG = 8'h01;
    localparam logic [7:0] MA_LATENCY = 8'h02;
    localparam logic [7:0] MA_BANK_MASK = 8'h10;
    localparam logic [7:0] MA_SEG_MASK = 8'h11;
    localparam logic [7:0] MA_PATTERN_A = 8'h20;
    localparam logic [7:0] MA_PATTERN_B = 8'h28;
    localparam logic [7:0] MA_SOFT_RESET = 8'h3F;

    // Reset values and minimum read latency
    localparam logic [7:0] BANK_MASK_RST = 8'h00;
    localparam logic [7:0] SEG_MASK_RST = 8'h00;
    localparam logic [2:0] BL_CODE_RST = 3'h2;
    localparam logic [3:0] RL_RST = 4'h3;
    localparam logic [3:0] RL_MIN = 4'h1;

    // Burst length codes and beat counts
    localparam logic [2:0] BL_CODE_4 = 3'h2;
    localparam logic [2:0] BL_CODE_8 = 3'h3;
    localparam logic [2:0] BL_CODE_16 = 3'h4;
    localparam logic [4:0] BEATS_4 = 5'h04;
    localparam logic [4:0] BEATS_8 = 5'h08;
    localparam logic [4:0] BEATS_16 = 5'h10;

    // Field positions on the command/address bus and in the row address
    localparam int unsigned CA_BANK_LSB = 7;
    localparam int unsigned CA_ALL_BANK_BIT = 4;
    localparam int unsigned SEG_ROW_LSB = 11;

    // Row-to-column delay
    localparam int unsigned TCK_NS = 10;
    localparam int unsigned TRCD_NS = 18;
    localparam int unsigned TRCD_CYC = (TRCD_NS + TCK_NS - 1) / TCK_NS;
    localparam logic [1:0] TRCD_LOAD = 2'(TRCD_CYC - 1);

    typedef enum logic [2:0] {
        CMD_NOP = 3'b000,
        CMD_ACT = 3'b001,
        CMD_RD  = 3'b010,
        CMD_WR  = 3'b011,
        CMD_PRE = 3'b100,
        CMD_MRW = 3'b101,
        CMD_MRR = 3'b110
    } sbk_cmd_e;

    typedef enum logic [1:0] {
        XFER_IDLE  = 2'b00,
        XFER_READ  = 2'b01,
        XFER_WRITE = 2'b10,
        XFER_MRR   = 2'b11
    } sbk_xfer_e;

    function automatic sbk_cmd_e sbk_decode(input logic cs_n, input logic cke,
                                            input logic [CA_W-1:0] ca);
        sbk_cmd_e c;
        c = CMD_NOP;
        if (!cs_n && cke) begin
            case (ca[1:0])
                2'b10: c = CMD_ACT;
                2'b01: c = ca[2] ? CMD_RD : CMD_WR;
                2'b11: c = (!ca[2] && ca[3]) ? CMD_PRE : CMD_NOP;
                2'b00: c = ca[2] ? CMD_NOP : (ca[3] ? CMD_MRR : CMD_MRW);
                default: c = CMD_NOP;
            endcase
        end
        return c;
    endfunction

    function automatic logic [4:0] sbk_bl_beats(input logic [2:0] code);
        logic [4:0] b;
        case (code)
            BL_CODE_8: b = BEATS_8;
            BL_CODE_16: b = BEATS_16;
            default: b = BEATS_4;
        endcase
        return b;
    endfunction

    // Sequential column order, wrapping inside the burst-aligned block
    function automatic logic [COL_W-1:0] sbk_burst_col(input logic [COL_W-1:0] base,
                                                       input logic [3:0] beat,
                                                       input logic [4:0] beats);
        logic [COL_W-1:0] m;
        logic [COL_W-1:0] s;
        m = {5'h00, beats - 5'h01};
        s = base + {6'h00, beat};
        return (base & ~m) | (s & m);
    endfunction

endpackage

/* hw/sbk_device_core.sv */
`timescale 1ns/1ps
module sbk_device_core import sbk_pkg::*; #(
    parameter logic [7:0] PATTERN_A = 8'h55, // Arbitrary calibration pattern
    parameter logic [7:0] PATTERN_B = 8'h33 // Arbitrary calibration pattern
) (
    input wire logic core_clk_i, // Core clock
    input wire logic arst_n_i, // Async reset, active low
    input wire logic cke_i, // Clock enable pin
    input wire logic cs_n_i, // Chip select pin, active low
    input wire logic [CA_W-1:0] ca_rise_i, // CA bus, rising-edge half
    input wire logic [CA_W-1:0] ca_fall_i, // CA bus, falling-edge half
    input wire logic [DQ_W-1:0] dq_i, // Data pins, input side
    input wire logic [DQ_W-1:0] arr_rdata_i, // Array read data, same cycle
    output logic [DQ_W-1:0] dq_o, // Data pins, output side
    output logic dq_oe_o, // Data pins drive enable
    output logic dqs_o, // Data strobe
    output logic dqs_oe_o, // Data strobe drive enable
    output logic arr_valid_o, // Array beat access
    output logic arr_write_o, // Array beat is a write
    output logic [BANK_W-1:0] arr_bank_o, // Array bank
    output logic [ROW_W-1:0] arr_row_o, // Array row
    output logic [COL_W-1:0] arr_col_o, // Array column
    output logic [DQ_W-1:0] arr_wdata_o, // Array write data
    output logic [NUM_BANKS-1:0] bank_active_o, // Bank open flags
    output logic [7:0] bank_refresh_mask_o, // Bank refresh mask
    output logic [7:0] segment_refresh_mask_o, // Segment refresh mask
    output logic [NUM_BANKS-1:0] refresh_blocked_o, // Open row of bank is masked
    output logic cmd_error_o // Illegal command seen, pulse
);

    logic cke_s1_q, cke_s2_q, cs_n_s1_q, cs_n_s2_q;
    logic [CA_W-1:0] car_s1_q, car_s2_q, caf_s1_q, caf_s2_q;
    logic [DQ_W-1:0] dq_s1_q, dq_s2_q;

    // Pin synchronisers
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cke_s1_q <= 1'b0;
            cke_s2_q <= 1'b0;
            cs_n_s1_q <= 1'b1;
            cs_n_s2_q <= 1'b1;
            car_s1_q <= '0;
            car_s2_q <= '0;
            caf_s1_q <= '0;
            caf_s2_q <= '0;
            dq_s1_q <= '0;
            dq_s2_q <= '0;
        end else begin
            cke_s1_q <= cke_i;
            cke_s2_q <= cke_s1_q;
            cs_n_s1_q <= cs_n_i;
            cs_n_s2_q <= cs_n_s1_q;
            car_s1_q <= ca_rise_i;
            car_s2_q <= car_s1_q;
            caf_s1_q <= ca_fall_i;
            caf_s2_q <= caf_s1_q;
            dq_s1_q <= dq_i;
            dq_s2_q <= dq_s1_q;
        end
    end

    logic [NUM_BANKS-1:0] active_q, active_d;
    logic [ROW_W-1:0] open_row_q [NUM_BANKS];
    logic [ROW_W-1:0] open_row_d [NUM_BANKS];
    logic [1:0] rcd_q [NUM_BANKS];
    logic [1:0] rcd_d [NUM_BANKS];
    logic [7:0] bank_mask_q, bank_mask_d, seg_mask_q, seg_mask_d;
    logic [2:0] bl_code_q, bl_code_d;
    logic [3:0] rl_q, rl_d;
    sbk_xfer_e pipe_kind_q [PIPE_DEPTH];
    sbk_xfer_e pipe_kind_d [PIPE_DEPTH];
    logic [BANK_W-1:0] pipe_bank_q [PIPE_DEPTH];
    logic [BANK_W-1:0] pipe_bank_d [PIPE_DEPTH];
    logic [COL_W-1:0] pipe_col_q [PIPE_DEPTH];
    logic [COL_W-1:0] pipe_col_d [PIPE_DEPTH];
    sbk_xfer_e xfer_q, xfer_d;
    logic [3:0] beat_q, beat_d;
    logic [4:0] beats_q, beats_d;
    logic [BANK_W-1:0] eng_bank_q, eng_bank_d;
    logic [COL_W-1:0] base_q, base_d;
    logic [DQ_W-1:0] dq_q, dq_d, wdata_q, wdata_d;
    logic dq_oe_q, dq_oe_d, dqs_q, dqs_d, dqs_oe_q, dqs_oe_d;
    logic arr_valid_q, arr_valid_d, arr_write_q, arr_write_d, err_q, err_d;
    logic [BANK_W-1:0] arr_bank_q, arr_bank_d;
    logic [ROW_W-1:0] arr_row_q, arr_row_d;
    logic [COL_W-1:0] arr_col_q, arr_col_d;
    logic [NUM_BANKS-1:0] blk_q, blk_d;

    sbk_cmd_e cmd;
    logic [BANK_W-1:0] cbank;
    logic [7:0] ma, op;
    sbk_xfer_e launch;
    logic [3:0] li;
    logic rdbeat;

    always_comb begin
        cmd = sbk_decode(cs_n_s2_q, cke_s2_q, car_s2_q);
        cbank = car_s2_q[CA_BANK_LSB +: BANK_W];
        ma = {caf_s2_q[1:0], car_s2_q[9:4]};
        op = caf_s2_q[9:2];
        active_d = active_q;
        open_row_d = open_row_q;
        bank_mask_d = bank_mask_q;
        seg_mask_d = seg_mask_q;
        bl_code_d = bl_code_q;
        rl_d = rl_q;
        err_d = 1'b0;
        for (int b = 0; b < NUM_BANKS; b++) begin
            rcd_d[b] = (rcd_q[b] != 2'h0) ? rcd_q[b] - 2'h1 : 2'h0;
        end
        for (int i = PIPE_DEPTH - 1; i > 0; i--) begin
            pipe_kind_d[i] = pipe_kind_q[i-1];
            pipe_bank_d[i] = pipe_bank_q[i-1];
            pipe_col_d[i] = pipe_col_q[i-1];
        end
        pipe_kind_d[0] = XFER_IDLE;
        pipe_bank_d[0] = cbank;
        pipe_col_d[0] = '0;
        case (cmd)
            CMD_ACT: begin
                if (active_q[cbank]) begin
                    err_d = 1'b1;
                end else begin
                    active_d[cbank] = 1'b1;
                    open_row_d[cbank] = {car_s2_q[6:3], caf_s2_q};
                    rcd_d[cbank] = TRCD_LOAD;
                end
            end
            CMD_RD, CMD_WR: begin
                if (!active_q[cbank] || rcd_q[cbank] != 2'h0) begin
                    err_d = 1'b1;
                end else begin
                    pipe_kind_d[0] = (cmd == CMD_RD) ? XFER_READ : XFER_WRITE;
                    pipe_col_d[0] = {caf_s2_q[7:1], car_s2_q[6:5], 1'b0};
                end
            end
            CMD_PRE: begin
                if (car_s2_q[CA_ALL_BANK_BIT]) begin
                    active_d = '0;
                end else begin
                    active_d[cbank] = 1'b0;
                end
            end
            CMD_MRW: begin
                case (ma)
                    MA_BANK_MASK: bank_mask_d = op;
                    MA_SEG_MASK: seg_mask_d = op;
                    MA_BURST_CFG: bl_code_d = op[2:0];
                    MA_LATENCY: rl_d = (op[3:0] == 4'h0) ? RL_MIN : op[3:0];
                    default: ; // Reserved and read-only addresses are ignored
                endcase
            end
            CMD_MRR: begin
                pipe_kind_d[0] = XFER_MRR;
                case (ma)
                    MA_PATTERN_A: pipe_col_d[0] = {2'h0, PATTERN_A};
                    MA_PATTERN_B: pipe_col_d[0] = {2'h0, PATTERN_B};
                    default: pipe_col_d[0] = '0;
                endcase
            end
            default: ;
        endcase

        // Burst engine: a newly due command replaces any running burst
        li = rl_q - 4'h1;
        launch = pipe_kind_q[li];
        xfer_d = xfer_q;
        beat_d = beat_q;
        beats_d = beats_q;
        eng_bank_d = eng_bank_q;
        base_d = base_q;
        if (launch != XFER_IDLE) begin
            xfer_d = launch;
            beat_d = 4'h0;
            beats_d = (launch == XFER_MRR) ? BEATS_4 : sbk_bl_beats(bl_code_q);
            eng_bank_d = pipe_bank_q[li];
            base_d = pipe_col_q[li];
        end else if (xfer_q != XFER_IDLE) begin
            if ({1'b0, beat_q} == beats_q - 5'h01) begin
                xfer_d = XFER_IDLE;
            end else begin
                beat_d = beat_q + 4'h1;
            end
        end

        // Soft reset write; operand bits are not looked at
        if (cmd == CMD_MRW && ma == MA_SOFT_RESET) begin
            active_d = '0;
            bank_mask_d = BANK_MASK_RST;
            seg_mask_d = SEG_MASK_RST;
            bl_code_d = BL_CODE_RST;
            rl_d = RL_RST;
            xfer_d = XFER_IDLE;
            for (int i = 0; i < PIPE_DEPTH; i++) begin
                pipe_kind_d[i] = XFER_IDLE;
            end
        end

        arr_valid_d = (xfer_d == XFER_READ) || (xfer_d == XFER_WRITE);
        arr_write_d = (xfer_d == XFER_WRITE);
        arr_bank_d = eng_bank_d;
        arr_row_d = open_row_q[eng_bank_d];
        arr_col_d = sbk_burst_col(base_d, beat_d, beats_d);
        wdata_d = dq_s2_q;

        rdbeat = (xfer_q == XFER_READ) || (xfer_q == XFER_MRR);
        dq_oe_d = rdbeat;
        if (xfer_q == XFER_MRR) begin
            dq_d = (beat_q == 4'h0) ? {8'h00, base_q[7:0]} : '0;
        end else begin
            dq_d = rdbeat ? arr_rdata_i : '0;
        end
        dqs_oe_d = rdbeat || (launch == XFER_READ) || (launch == XFER_MRR);
        dqs_d = rdbeat && !beat_q[0];

        for (int b = 0; b < NUM_BANKS; b++) begin
            blk_d[b] = active_q[b] && (bank_mask_q[b] ||
                       seg_mask_q[open_row_q[b][SEG_ROW_LSB +: 3]]);
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            active_q <= '0;
            bank_mask_q <= BANK_MASK_RST;
            seg_mask_q <= SEG_MASK_RST;
            bl_code_q <= BL_CODE_RST;
            rl_q <= RL_RST;
            for (int b = 0; b < NUM_BANKS; b++) begin
                open_row_q[b] <= '0;
                rcd_q[b] <= 2'h0;
            end
            for (int i = 0; i < PIPE_DEPTH; i++) begin
                pipe_kind_q[i] <= XFER_IDLE;
                pipe_bank_q[i] <= '0;
                pipe_col_q[i] <= '0;
            end
            xfer_q <= XFER_IDLE;
            beat_q <= 4'h0;
            beats_q <= BEATS_4;
            eng_bank_q <= '0;
            base_q <= '0;
            dq_q <= '0;
            dq_oe_q <= 1'b0;
            dqs_q <= 1'b0;
            dqs_oe_q <= 1'b0;
            arr_valid_q <= 1'b0;
            arr_write_q <= 1'b0;
            arr_bank_q <= '0;
            arr_row_q <= '0;
            arr_col_q <= '0;
            wdata_q <= '0;
            blk_q <= '0;
            err_q <= 1'b0;
        end else begin
            active_q <= active_d;
            bank_mask_q <= bank_mask_d;
            seg_mask_q <= seg_mask_d;
            bl_code_q <= bl_code_d;
            rl_q <= rl_d;
            open_row_q <= open_row_d;
            rcd_q <= rcd_d;
            pipe_kind_q <= pipe_kind_d;
            pipe_bank_q <= pipe_bank_d;
            pipe_col_q <= pipe_col_d;
            xfer_q <= xfer_d;
            beat_q <= beat_d;
            beats_q <= beats_d;
            eng_bank_q <= eng_bank_d;
            base_q <= base_d;
            dq_q <= dq_d;
            dq_oe_q <= dq_oe_d;
            dqs_q <= dqs_d;
            dqs_oe_q <= dqs_oe_d;
            arr_valid_q <= arr_valid_d;
            arr_write_q <= arr_write_d;
            arr_bank_q <= arr_bank_d;
            arr_row_q <= arr_row_d;
            arr_col_q <= arr_col_d;
            wdata_q <= wdata_d;
            blk_q <= blk_d;
            err_q <= err_d;
        end
    end

    assign dq_o = dq_q;
    assign dq_oe_o = dq_oe_q;
    assign dqs_o = dqs_q;
    assign dqs_oe_o = dqs_oe_q;
    assign arr_valid_o = arr_valid_q;
    assign arr_write_o = arr_write_q;
    assign arr_bank_o = arr_bank_q;
    assign arr_row_o = arr_row_q;
    assign arr_col_o = arr_col_q;
    assign arr_wdata_o = wdata_q;
    assign bank_active_o = active_q;
    assign bank_refresh_mask_o = bank_mask_q;
    assign segment_refresh_mask_o = seg_mask_q;
    assign refresh_blocked_o = blk_q;
    assign cmd_error_o = err_q;

endmodule // sbk_device_core

/* tb/sbk_device_core_chk.sv */
`timescale 1ns/1ps
module sbk_device_core_chk import sbk_pkg::*; #(
    parameter logic [7:0] PATTERN_A = 8'h55, // Pattern at 20h
    parameter logic [7:0] PATTERN_B = 8'h33 // Pattern at 28h
) (
    input wire logic core_clk_i, // Clock
    input wire logic arst_n_i, // Reset
    input wire logic cke_i, // Clock enable
    input wire logic cs_n_i, // Chip select
    input wire logic [CA_W-1:0] ca_rise_i, // CA rise
    input wire logic [CA_W-1:0] ca_fall_i, // CA fall
    input wire logic [DQ_W-1:0] dq_o, // Data
    input wire logic dq_oe_o, // Data enable
    input wire logic dqs_o, // Strobe
    input wire logic dqs_oe_o, // Strobe enable
    input wire logic arr_valid_o, // Beat
    input wire logic arr_write_o, // Beat is write
    input wire logic [COL_W-1:0] arr_col_o, // Column
    input wire logic [NUM_BANKS-1:0] bank_active_o, // Open banks
    input wire logic [7:0] bank_refresh_mask_o, // Bank mask
    input wire logic [7:0] segment_refresh_mask_o, // Segment mask
    input wire logic cmd_error_o // Error pulse
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!arst_n_i);
    logic sel, act, col, mode_register_write, mrr;
    logic [7:0] ma;
    logic [2:0] bk;
    assign sel = !cs_n_i && cke_i;
    assign act = sel && ca_rise_i[1:0] == 2'b10;
    assign col = sel && ca_rise_i[1:0] == 2'b01;
    assign mode_register_write = sel && ca_rise_i[3:0] == 4'h0;
    assign mrr = sel && ca_rise_i[3:0] == 4'h8;
    assign ma = {ca_fall_i[1:0], ca_rise_i[9:4]};
    assign bk = ca_rise_i[9:7];
    sequence s_col_ok;
        col ##2 bank_active_o[$past(bk, 2)] ##1 !cmd_error_o;
    endsequence
    sequence s_burst4;
        arr_valid_o [*4] ##1 !arr_valid_o;
    endsequence
    a_act_opens: assert property (act |-> ##3 bank_active_o[$past(bk, 3)])
        else $error("activate did not open bank");
    a_idle_col_err: assert property (col ##2 !bank_active_o[$past(bk, 2)] |-> ##1 cmd_error_o)
        else $error("column access to idle bank not flagged");
    a_col_burst: assert property (s_col_ok |-> ##3 s_burst4)
        else $error("burst not four beats at latency");
    a_col_start: assert property (s_col_ok |-> ##3 arr_write_o == !$past(ca_rise_i[2], 6) &&
        arr_col_o == {$past(ca_fall_i[7:1], 6), $past(ca_rise_i[6:5], 6), 1'b0})
        else $error("wrong start column or direction");
    a_bank_mask: assert property (mode_register_write && ma == MA_BANK_MASK |->
        ##3 bank_refresh_mask_o == $past(ca_fall_i[9:2], 3))
        else $error("bank mask not written");
    a_soft_reset: assert property (mode_register_write && ma == MA_SOFT_RESET |-> ##3 bank_active_o == '0 &&
        bank_refresh_mask_o == 8'h00 && segment_refresh_mask_o == 8'h00)
        else $error("soft reset incomplete");
    a_pattern_read: assert property (mrr && (ma == MA_PATTERN_A || ma == MA_PATTERN_B) |->
        ##7 dq_oe_o && dq_o == {8'h00, $past(ma, 7) == MA_PATTERN_A ? PATTERN_A : PATTERN_B})
        else $error("calibration pattern wrong");
    a_preamble: assert property ($rose(dqs_oe_o) |-> !dqs_o ##1 (dqs_o && dq_oe_o))
        else $error("strobe preamble wrong");
endmodule // sbk_device_core_chk

bind sbk_device_core sbk_device_core_chk #(.PATTERN_A(PATTERN_A), .PATTERN_B(PATTERN_B)) u_chk (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .cke_i(cke_i), .cs_n_i(cs_n_i),
    .ca_rise_i(ca_rise_i), .ca_fall_i(ca_fall_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
    .dqs_o(dqs_o), .dqs_oe_o(dqs_oe_o), .arr_valid_o(arr_valid_o), .arr_write_o(arr_write_o),
    .arr_col_o(arr_col_o), .bank_active_o(bank_active_o),
    .bank_refresh_mask_o(bank_refresh_mask_o),
    .segment_refresh_mask_o(segment_refresh_mask_o), .cmd_error_o(cmd_error_o)
);

/* tb/sbk_host.sv */
`timescale 1ns/1ps
module sbk_host import sbk_pkg::*; (
    input wire logic core_clk_i, // Clock
    output logic cke_o, // Clock enable
    output logic cs_n_o, // Chip select
    output logic [CA_W-1:0] ca_rise_o, // CA rise
    output logic [CA_W-1:0] ca_fall_o, // CA fall
    output logic [DQ_W-1:0] dq_o // Write data
);
    logic hold = 1'b0;
    initial begin
        cke_o = 1'b1;
        cs_n_o = 1'b1;
        ca_rise_o = '0;
        ca_fall_o = '0;
        dq_o = '0;
    end
    task automatic set_dq(input logic [DQ_W-1:0] v, input logic h);
        dq_o = v;
        hold = h;
    endtask
    // Deselected bus and unused data lines carry noise, never the last value
    task automatic idle(input int n);
        repeat (n) begin
            @(negedge core_clk_i);
            cs_n_o = 1'b1;
            ca_rise_o = CA_W'($urandom);
            ca_fall_o = CA_W'($urandom);
            if (!hold) dq_o = DQ_W'($urandom);
        end
    endtask
    // Caller spaces commands and uses documented addresses only
    task automatic cmd(input logic [19:0] rf, input int n);
        @(negedge core_clk_i);
        cs_n_o = 1'b0;
        {ca_rise_o, ca_fall_o} = rf;
        idle(n);
    endtask
endmodule // sbk_host

/* tb/sbk_device_core_bench.sv */
`timescale 1ns/1ps
`define CHK(g, e) chk(64'(g), 64'(e))
module sbk_device_core_bench import sbk_pkg::*;;
    localparam logic [7:0] PAT_A = 8'hA6; // Arbitrary value
    localparam logic [7:0] PAT_B = 8'h3C; // Arbitrary value
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic skip_arr = 1'b0;
    logic cke, cs_n, dq_oe, dqs, dqs_oe, valid, wr, err;
    logic [CA_W-1:0] ca_r, ca_f;
    logic [DQ_W-1:0] dq_in, dq, rdata, wdata;
    logic [2:0] bank;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
    logic [7:0] act_flags, bmask, smask, blocked, bm, sm, exp_blk;
    logic [43:0] qa[$];
    logic [15:0] qd[$];
    logic [13:0] rows[8];
    int err_total = 0;
    int n_compared = 0;
    int n_err = 0;
    always #5 clk = ~clk;
    assign rdata = {bank, col, row[2:0]};
    sbk_device_core #(.PATTERN_A(PAT_A), .PATTERN_B(PAT_B)) dut (
        .core_clk_i(clk), .arst_n_i(arst_n), .cke_i(cke), .cs_n_i(cs_n), .ca_rise_i(ca_r),
        .ca_fall_i(ca_f), .dq_i(dq_in), .arr_rdata_i(rdata), .dq_o(dq), .dq_oe_o(dq_oe),
        .dqs_o(dqs), .dqs_oe_o(dqs_oe), .arr_valid_o(valid), .arr_write_o(wr),
        .arr_bank_o(bank), .arr_row_o(row), .arr_col_o(col), .arr_wdata_o(wdata),
        .bank_active_o(act_flags), .bank_refresh_mask_o(bmask),
        .segment_refresh_mask_o(smask), .refresh_blocked_o(blocked), .cmd_error_o(err)
    );
    sbk_host host (.core_clk_i(clk), .cke_o(cke), .cs_n_o(cs_n), .ca_rise_o(ca_r),
        .ca_fall_o(ca_f), .dq_o(dq_in));
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic close_out();
        if (err_total == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    function automatic logic [19:0] f_act(input logic [2:0] b, input logic [13:0] r);
        return {b, r[13:10], 3'b010, r[9:0]};
    endfunction
    function automatic logic [19:0] f_col(input logic [2:0] b, input logic [9:0] c, input logic rd);
        return {b, c[2:1], 2'b00, rd, 2'b01, 2'b00, c[9:3], 1'b0};
    endfunction
    function automatic logic [19:0] f_mode(input logic [7:0] a, input logic [7:0] op, input logic rd);
        return {a[5:0], rd, 3'b000, op, a[7:6]};
    endfunction
    // Queues the four beats of one column access, then issues it
    task automatic xfer(input logic [2:0] b, input logic [9:0] c, input logic rd);
        logic [15:0] wd;
        logic [9:0] ck;
        wd = 16'($urandom);
        host.set_dq(wd, !rd);
        for (int k = 0; k < 4; k++) begin
            ck = {c[9:2], 2'(c[1:0] + 2'(k))};
            qa.push_back({!rd, b, rows[b], ck, rd ? 16'h0000 : wd});
            if (rd) qd.push_back({b, ck, rows[b][2:0]});
        end
        host.cmd(f_col(b, c, rd), 12);
        host.set_dq(wd, 1'b0);
    endtask
    always @(negedge clk) begin
        if (valid && !skip_arr) `CHK({wr, bank, row, col, wr ? wdata : 16'h0000}, qa.size() ? qa.pop_front() : 44'hX);
        if (dq_oe) `CHK(dq, qd.size() ? qd.pop_front() : 16'hXXXX);
        if (err === 1'b1) n_err++;
    end
    initial begin
        #20us;
        err_total++;
        close_out();
    end
    initial begin
        void'($urandom(32'h12ECD1DC));
        repeat (4) @(negedge clk);
        arst_n = 1'b1;
        `CHK({act_flags, bmask, smask, blocked, err}, 33'h0);
        bm = 8'($urandom);
        sm = 8'($urandom);
        host.cmd(f_mode(MA_BANK_MASK, bm, 1'b0), 2);
        host.cmd(f_mode(MA_SEG_MASK, sm, 1'b0), 3);
        `CHK({bmask, smask}, {bm, sm});
        host.cmd(f_col(3'h0, 10'h000, 1'b1), 4);
        for (int b = 0; b < 8; b++) begin
            rows[b] = 14'($urandom);
            exp_blk[b] = bm[b] | sm[rows[b][13:11]];
            host.cmd(f_act(3'(b), rows[b]), 2);
        end
        host.idle(2);
        `CHK({act_flags, blocked}, {8'hFF, exp_blk});
        host.cmd(f_act(3'h3, rows[3]), 4);
        host.cmd({3'h2, 17'h02C00}, 3);
        `CHK(act_flags, 8'hFB);
        host.cmd(f_col(3'h2, 10'h010, 1'b0), 4);
        rows[2] = 14'($urandom);
        host.cmd(f_act(3'h2, rows[2]), 0);
        host.cmd(f_col(3'h2, 10'h000, 1'b1), 0);
        xfer(3'h2, 10'h3FE, 1'b1);
        for (int i = 0; i < 8; i++) xfer(3'($urandom), {9'($urandom), 1'b0}, i[0]);
        skip_arr = 1'b1;
        for (int i = 0; i < 2; i++) begin
            qd.push_back({8'h00, i ? PAT_B : PAT_A});
            repeat (3) qd.push_back(16'h0000);
            host.cmd(f_mode(i ? MA_PATTERN_B : MA_PATTERN_A, 8'($urandom), 1'b1), 12);
        end
        skip_arr = 1'b0;
        host.cmd(f_mode(MA_SOFT_RESET, 8'($urandom), 1'b0), 4);
        `CHK({act_flags, bmask, smask, blocked}, 32'h0);
        `CHK({n_err[7:0], 8'(qa.size()), 8'(qd.size())}, 24'h040000);
        close_out();
    end
endmodule // sbk_device_core_bench
